/* common/tagrw_pkg.sv */
// Package: constants, switch codes and state type of the tag byte control block
package tagrw_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
    localparam int unsigned NORM_DLY_MS  = 3;
    localparam int unsigned OUT_SHORT_MS = 10;
    localparam int unsigned OUT_LONG_MS  = 50;
    localparam int unsigned CNT_W        = 24;

    localparam logic [CNT_W-1:0] NORM_DLY_CYC  = CNT_W'(NORM_DLY_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] OUT_SHORT_CYC = CNT_W'(OUT_SHORT_MS * CYC_PER_MS);
    localparam logic [CNT_W-1:0] OUT_LONG_CYC  = CNT_W'(OUT_LONG_MS * CYC_PER_MS);

    // ==========================================================
    // Switch codes
    // ==========================================================
    localparam logic [1:0] OT_SHORT = 2'h0;
    localparam logic [1:0] OT_LONG  = 2'h1;
    localparam logic [1:0] WM_BYTE  = 2'h0;
    localparam logic [1:0] WM_SET   = 2'h1;
    localparam logic [1:0] WM_CLR   = 2'h2;

    // ==========================================================
    // Values
    // ==========================================================
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [7:0] CMP_MATCH  = 8'h01;
    localparam logic [7:0] CMP_DIFFER = 8'h80;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RD,
        S_WR,
        S_CHK,
        S_WAIT3,
        S_OUT,
        S_HOLD
    } state_t;

endpackage : tagrw_pkg

/* common/timer_if.sv */
// Interface: load, length and expiry of the shared countdown timer
`timescale 1ns/1ps
interface timer_if;
    import tagrw_pkg::*;
    logic             load;
    logic [CNT_W-1:0] len;
    logic             done;
    modport ctl (output load, output len, input done);
    modport tmr (input load, input len, output done);
endinterface : timer_if

/* logic/pulse_timer.sv */
// Countdown timer used for the normal-end delay and the output time
`timescale 1ns/1ps
module pulse_timer (
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    timer_if.tmr       t
);
    import tagrw_pkg::*;

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else if (t.load) begin
            cnt_q <= t.len;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    // Last counted cycle; the owner leaves its state on the next edge
    assign t.done = (cnt_q == CNT_W'(1));

endmodule : pulse_timer

/* logic/tag_byte_read_write_control.sv */
// Tag byte read/write control: host pins, mode switches and tag access sequencing
// Function
// [R1] Plain read: read byte at switch address, drive it onto data outputs.
// [R2] After read data is shown, wait 3 ms, then pulse normal-end.
// [R3] Triggered mode: data outputs held until start input is next asserted.
// [R4] Self-triggered mode: data outputs kept until a later read gives data.
// [R5] Self-triggered mode: hold input forces all data outputs to zero.
// [R6] Failed read in either read mode pulses error-end for output time.
// [R7] Compare read: bit 0 on match, bit 7 on mismatch, output time.
// [R8] Every write is read back and confirmed; mismatch is a write failure.
// [R9] Whole-byte write stores the host byte at the switch address.
// [R10] Bit-set write sets tag bits whose host input is high.
// [R11] Bit-clear write clears tag bits whose host input is high.
// [R12] Successful write pulses normal-end for the output time.
// [R13] Failed write pulses error-end for the output time.
// [R14] Read or write chosen only by the host write-select line.
// [R15] Self mode: access once per tag entry; re-arm on leave or hold release.
// [R16] Triggered mode: start rise accesses at once; no tag gives error-end.
// [R17] Any reported error drives all data outputs to zero.
// [R18] Hold_until_cleared output time: ends held until hold or start input asserted.
// [R19] Host keeps write-select and data inputs stable during an access.
// [R20] Mode and time switches are sampled once after reset only.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tag_byte_read_write_control #(
    parameter logic [tagrw_pkg::CNT_W-1:0] P_NORM_DLY_CYC  = tagrw_pkg::NORM_DLY_CYC,
    parameter logic [tagrw_pkg::CNT_W-1:0] P_OUT_SHORT_CYC = tagrw_pkg::OUT_SHORT_CYC,
    parameter logic [tagrw_pkg::CNT_W-1:0] P_OUT_LONG_CYC  = tagrw_pkg::OUT_LONG_CYC
) (
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST,
    // Switches
    input  wire logic [7:0] I_ADDR_SW,
    input  wire logic       I_SELF_TRIG_SW,
    input  wire logic [1:0] I_OUT_TIME_SW,
    input  wire logic       I_COMPARE_READ_SW,
    input  wire logic [1:0] I_WRITE_MODE_SW,
    // Host side
    input  wire logic [7:0] I_HOST_BYTE_IN,
    input  wire logic       I_WRITE_SELECT,
    input  wire logic       I_ACCESS_START_IN,
    input  wire logic       I_ACCESS_HOLD_IN,
    output logic      [7:0] O_CARRIER_DATA_OUT,
    output logic            O_NORMAL_END,
    output logic            O_ERROR_END,
    // Tag link
    input  wire logic       I_TAG_PRESENT,
    input  wire logic       I_TAG_ACK,
    input  wire logic       I_TAG_FAIL,
    input  wire logic [7:0] I_TAG_RDATA,
    output logic            O_TAG_REQ,
    output logic            O_TAG_WRITE,
    output logic      [7:0] O_TAG_ADDR,
    output logic      [7:0] O_TAG_WDATA
);
    import tagrw_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    state_t     state_q;
    logic       cfg_pend_q;
    logic       self_q;
    logic [1:0] otime_q;
    logic       cmp_q;
    logic [1:0] wmode_q;
    logic       wsel_q;
    logic       start_prev_q;
    logic       hold_prev_q;
    logic       armed_q;
    logic [7:0] expect_q;
    logic [7:0] data_q;
    logic       normal_q;
    logic       error_q;
    logic       req_q;
    logic       wr_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;

    logic       start_rise;
    logic       hold_fall;
    logic       cont;
    logic       go;
    logic       ok_c;
    logic       fail_c;
    logic       release_c;
    logic [7:0] merged;
    logic [CNT_W-1:0] out_len;

    timer_if tmr ();

    pulse_timer u_timer (
        .i_clk (I_CLOCK),
        .i_rst (I_RST),
        .t     (tmr.tmr)
    );

    // ==========================================================
    // Switch capture
    // ==========================================================
    // Captured one edge after reset release, never again
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            cfg_pend_q <= 1'b1;
            self_q     <= 1'b0;
            otime_q    <= OT_SHORT;
            cmp_q      <= 1'b0;
            wmode_q    <= WM_BYTE;
        end else if (cfg_pend_q) begin  // see [R20]
            cfg_pend_q <= 1'b0;
            self_q     <= I_SELF_TRIG_SW;
            otime_q    <= I_OUT_TIME_SW;
            cmp_q      <= I_COMPARE_READ_SW;
            wmode_q    <= I_WRITE_MODE_SW;
        end
    end

    // Codes 2 and 3 both hold the ends until released
    assign cont = (otime_q != OT_SHORT) && (otime_q != OT_LONG);
    assign out_len = (otime_q == OT_LONG) ? P_OUT_LONG_CYC : P_OUT_SHORT_CYC;

    // ==========================================================
    // Input edges and self-trigger arming
    // ==========================================================
    // Reset to the pins' idle level, so no false edge follows reset
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            start_prev_q <= 1'b0;
            hold_prev_q  <= 1'b0;
        end else begin
            start_prev_q <= I_ACCESS_START_IN;
            hold_prev_q  <= I_ACCESS_HOLD_IN;
        end
    end

    assign start_rise = I_ACCESS_START_IN & ~start_prev_q;
    assign hold_fall  = hold_prev_q & ~I_ACCESS_HOLD_IN;

    // Launch disarms; tag absence or hold release re-arms; launch wins when both come in one cycle
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            armed_q <= 1'b1;
        end else if (go && self_q) begin
            armed_q <= 1'b0;  // see [R15]
        end else if (!I_TAG_PRESENT || hold_fall) begin
            armed_q <= 1'b1;  // see [R15]
        end
    end

    // ==========================================================
    // Launch, completion and failure decisions
    // ==========================================================
    always_comb begin
        go        = 1'b0;
        release_c = 1'b0;
        ok_c      = 1'b0;
        fail_c    = 1'b0;
        if (!cfg_pend_q && (state_q == S_IDLE || state_q == S_HOLD)) begin
            if (self_q) begin
                go = armed_q && I_TAG_PRESENT && !I_ACCESS_HOLD_IN;  // see [R15]
                release_c = I_ACCESS_HOLD_IN;  // see [R18]
            end else begin
                go = start_rise && I_TAG_PRESENT;  // see [R16]
                release_c = start_rise;  // see [R18]
                fail_c = start_rise && !I_TAG_PRESENT;  // see [R16]
            end
        end
        case (state_q)
            S_RD: begin
                fail_c = I_TAG_ACK && I_TAG_FAIL;  // see [R6]
            end
            S_WR: begin
                fail_c = I_TAG_ACK && I_TAG_FAIL;  // see [R13]
            end
            S_CHK: begin
                fail_c = I_TAG_ACK && (I_TAG_FAIL || I_TAG_RDATA != expect_q);  // see [R8]
                ok_c   = I_TAG_ACK && !I_TAG_FAIL && I_TAG_RDATA == expect_q;  // see [R12]
            end
            S_WAIT3: begin
                ok_c = tmr.done;  // see [R2]
            end
            default: begin
            end
        endcase
    end

    // New tag byte from the current one and the host byte
    always_comb begin
        if (wmode_q == WM_SET) begin
            merged = I_TAG_RDATA | I_HOST_BYTE_IN;  // see [R10]
        end else if (wmode_q == WM_CLR) begin
            merged = I_TAG_RDATA & ~I_HOST_BYTE_IN;  // see [R11]
        end else begin
            merged = I_HOST_BYTE_IN;  // see [R9]
        end
    end

    // ==========================================================
    // Sequencer and tag link
    // ==========================================================
    // Writes always read the byte first so that bit modes can merge
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            state_q  <= S_IDLE;
            req_q    <= 1'b0;
            wr_q     <= 1'b0;
            addr_q   <= BYTE_ZERO;
            wdata_q  <= BYTE_ZERO;
            expect_q <= BYTE_ZERO;
            wsel_q   <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE, S_HOLD: begin
                    if (release_c) begin
                        state_q <= S_IDLE;
                    end
                    if (go) begin
                        wsel_q  <= I_WRITE_SELECT;  // see [R14]
                        addr_q  <= I_ADDR_SW;  // see [R1]
                        req_q   <= 1'b1;
                        wr_q    <= 1'b0;
                        state_q <= S_RD;
                    end
                end
                S_RD: begin
                    if (I_TAG_ACK && !I_TAG_FAIL) begin
                        if (wsel_q) begin
                            expect_q <= merged;
                            wdata_q  <= merged;
                            wr_q     <= 1'b1;
                            state_q  <= S_WR;
                        end else begin
                            req_q   <= 1'b0;
                            state_q <= S_WAIT3;
                        end
                    end
                end
                S_WR: begin
                    if (I_TAG_ACK && !I_TAG_FAIL) begin
                        wr_q    <= 1'b0;
                        state_q <= S_CHK;  // see [R8]
                    end
                end
                S_CHK: begin
                    // No link timeout: a silent tag leaves the sequencer here
                    if (I_TAG_ACK) begin
                        req_q <= 1'b0;
                    end
                end
                S_OUT: begin
                    if (tmr.done) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                end
            endcase
            // End decisions override any step taken by the case above
            if (ok_c || fail_c) begin
                req_q   <= 1'b0;
                wr_q    <= 1'b0;
                state_q <= cont ? S_HOLD : S_OUT;
            end
        end
    end

    // ==========================================================
    // Timer control
    // ==========================================================
    // One timer serves the 3 ms delay and the output time; they never overlap
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            tmr.load <= 1'b0;
            tmr.len  <= '0;
        end else begin
            tmr.load <= 1'b0;
            if (state_q == S_RD && I_TAG_ACK && !I_TAG_FAIL && !wsel_q) begin
                tmr.load <= 1'b1;
                tmr.len  <= P_NORM_DLY_CYC;  // see [R2]
            end else if ((ok_c || fail_c) && !cont) begin
                tmr.load <= 1'b1;
                tmr.len  <= out_len;
            end
        end
    end

    // ==========================================================
    // Host outputs
    // ==========================================================
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            data_q   <= BYTE_ZERO;
            normal_q <= 1'b0;
            error_q  <= 1'b0;
        end else begin
            if (release_c && state_q == S_HOLD) begin
                normal_q <= 1'b0;  // see [R18]
                error_q  <= 1'b0;  // see [R18]
            end
            if (go && !self_q) begin
                data_q <= BYTE_ZERO;  // see [R3]
            end
            if (state_q == S_RD && I_TAG_ACK && !I_TAG_FAIL && !wsel_q) begin
                // Host byte taken at the read ack; the host keeps it stable
                if (cmp_q) begin
                    data_q <= (I_TAG_RDATA == I_HOST_BYTE_IN) ? CMP_MATCH : CMP_DIFFER;  // see [R7]
                end else begin
                    data_q <= I_TAG_RDATA;  // see [R1] [R4]
                end
            end
            if (state_q == S_CHK && ok_c) begin
                data_q <= expect_q;
            end
            if (state_q == S_OUT && tmr.done) begin
                normal_q <= 1'b0;
                error_q  <= 1'b0;
                if (cmp_q && !wsel_q) begin
                    data_q <= BYTE_ZERO;  // see [R7]
                end
            end
            if (ok_c) begin
                normal_q <= 1'b1;  // see [R2] [R12]
            end
            if (fail_c) begin
                error_q <= 1'b1;  // see [R6] [R13]
                data_q  <= BYTE_ZERO;  // see [R17]
            end
            // Last, so hold forcing wins over read data of the same cycle
            if (self_q && I_ACCESS_HOLD_IN) begin
                data_q <= BYTE_ZERO;  // see [R5]
            end
        end
    end

    assign O_CARRIER_DATA_OUT = data_q;
    assign O_NORMAL_END       = normal_q;
    assign O_ERROR_END        = error_q;
    assign O_TAG_REQ          = req_q;
    assign O_TAG_WRITE        = wr_q;
    assign O_TAG_ADDR         = addr_q;
    assign O_TAG_WDATA        = wdata_q;

endmodule : tag_byte_read_write_control

/* verification/tag_model.sv */
// Tag link partner: byte memory answering read and write requests
`timescale 1ns/1ps
module tag_model (
    input  wire logic       i_clk,
    input  wire logic       i_req,
    input  wire logic       i_write,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [1:0] i_fault,
    output logic            o_ack,
    output logic            o_fail,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [256];
    logic [1:0] cnt = 2'h0;
    initial o_ack = 1'b0;
    initial o_fail = 1'b0;
    initial o_rdata = 8'h5A;
    // ==========================================================
    // Link answers
    // ==========================================================
    always @(posedge i_clk) begin
        o_ack   <= 1'b0;
        o_fail  <= 1'b0;
        // Stale byte must not look valid outside an answer
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else begin
                o_ack  <= 1'b1;
                cnt    <= 2'($urandom_range(3));
                o_fail <= (i_fault == 2'h1);
                if (!i_write) begin
                    o_rdata <= mem[i_addr];
                end else if (i_fault != 2'h1) begin
                    // Fault 2 corrupts the stored byte to force a bad readback
                    mem[i_addr] <= i_wdata ^ {7'h00, i_fault == 2'h2};
                end
            end
        end
    end
endmodule : tag_model

/* verification/tagrw_monitor.sv */
// Checker: end outputs, data outputs and tag link of the tag byte block
`timescale 1ns/1ps
module tagrw_monitor #(
    parameter logic [tagrw_pkg::CNT_W-1:0] P_NORM_DLY_CYC = 24'h5
) (
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST,
    input  wire logic [7:0] I_ADDR_SW,
    input  wire logic       I_SELF_TRIG_SW,
    input  wire logic       I_WRITE_SELECT,
    input  wire logic       I_ACCESS_HOLD_IN,
    input  wire logic [7:0] O_CARRIER_DATA_OUT,
    input  wire logic       O_NORMAL_END,
    input  wire logic       O_ERROR_END,
    input  wire logic       I_TAG_ACK,
    input  wire logic       I_TAG_FAIL,
    input  wire logic [7:0] I_TAG_RDATA,
    input  wire logic       O_TAG_REQ,
    input  wire logic       O_TAG_WRITE,
    input  wire logic [7:0] O_TAG_ADDR,
    input  wire logic [7:0] O_TAG_WDATA
);
    import tagrw_pkg::*;
    localparam int ND = P_NORM_DLY_CYC + 2;
    logic first_q;
    logic self_q;
    logic wrote_q;
    logic ack_ok;
    assign ack_ok = I_TAG_ACK && O_TAG_REQ && !I_TAG_FAIL;
    // ==========================================================
    // Mode capture and write tracking
    // ==========================================================
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            first_q <= 1'b1;
            self_q  <= 1'b0;
        end else if (first_q) begin
            first_q <= 1'b0;
            self_q  <= I_SELF_TRIG_SW;
        end
    end
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            wrote_q <= 1'b0;
        end else if (I_TAG_ACK && O_TAG_REQ) begin
            wrote_q <= O_TAG_WRITE && !I_TAG_FAIL;
        end
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // ==========================================================
    // Properties
    // ==========================================================
    property p_norm_delay;
        ack_ok && !O_TAG_WRITE && !I_WRITE_SELECT |-> ##ND $rose(O_NORMAL_END);
    endproperty
    a_norm_delay: assert property (p_norm_delay) else $error("normal end delay wrong");
    property p_wr_ok;
        ack_ok && wrote_q && !O_TAG_WRITE && I_TAG_RDATA == O_TAG_WDATA
            |=> O_NORMAL_END && O_CARRIER_DATA_OUT == $past(O_TAG_WDATA);
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("write end wrong");
    property p_wr_bad;
        ack_ok && wrote_q && !O_TAG_WRITE && I_TAG_RDATA != O_TAG_WDATA |=> O_ERROR_END && !O_NORMAL_END;
    endproperty
    a_wr_bad: assert property (p_wr_bad) else $error("bad readback not an error");
    property p_fail;
        I_TAG_ACK && O_TAG_REQ && I_TAG_FAIL |=> O_ERROR_END;
    endproperty
    a_fail: assert property (p_fail) else $error("failed access not an error");
    property p_err_zero;
        O_ERROR_END |-> O_CARRIER_DATA_OUT == 8'h00;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("data not zero on error");
    property p_excl;
        !(O_NORMAL_END && O_ERROR_END);
    endproperty
    a_excl: assert property (p_excl) else $error("both ends high");
    property p_addr;
        $rose(O_TAG_REQ) |-> O_TAG_ADDR == $past(I_ADDR_SW);
    endproperty
    a_addr: assert property (p_addr) else $error("tag address not switch value");
    property p_hold;
        self_q && I_ACCESS_HOLD_IN |=> O_CARRIER_DATA_OUT == 8'h00;
    endproperty
    a_hold: assert property (p_hold) else $error("data not cleared by hold");
    c_norm: cover property ($rose(O_NORMAL_END));
    c_err: cover property ($rose(O_ERROR_END));
    c_hold: cover property (self_q && I_ACCESS_HOLD_IN);
endmodule : tagrw_monitor

bind tag_byte_read_write_control tagrw_monitor #(.P_NORM_DLY_CYC(P_NORM_DLY_CYC)) u_mon (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_ADDR_SW(I_ADDR_SW), .I_SELF_TRIG_SW(I_SELF_TRIG_SW),
    .I_WRITE_SELECT(I_WRITE_SELECT), .I_ACCESS_HOLD_IN(I_ACCESS_HOLD_IN),
    .O_CARRIER_DATA_OUT(O_CARRIER_DATA_OUT), .O_NORMAL_END(O_NORMAL_END), .O_ERROR_END(O_ERROR_END),
    .I_TAG_ACK(I_TAG_ACK), .I_TAG_FAIL(I_TAG_FAIL), .I_TAG_RDATA(I_TAG_RDATA), .O_TAG_REQ(O_TAG_REQ),
    .O_TAG_WRITE(O_TAG_WRITE), .O_TAG_ADDR(O_TAG_ADDR), .O_TAG_WDATA(O_TAG_WDATA));

/* verification/tb_tag_byte_read_write_control.sv */
// Testbench: host and switch stimulus with queued end-result checks
`timescale 1ns/1ps
module tb_tag_byte_read_write_control;
    import tagrw_pkg::*;
    logic       I_CLOCK = 1'b0, I_RST = 1'b1, I_SELF_TRIG_SW = 1'b0, I_COMPARE_READ_SW = 1'b0;
    logic       I_WRITE_SELECT = 1'b0, I_ACCESS_START_IN = 1'b0, I_ACCESS_HOLD_IN = 1'b0, I_TAG_PRESENT = 1'b0;
    logic [1:0] I_OUT_TIME_SW = 2'h0, I_WRITE_MODE_SW = 2'h0, fault = 2'h0;
    logic [7:0] I_ADDR_SW = 8'h00, I_HOST_BYTE_IN = 8'h00, O_CARRIER_DATA_OUT, O_TAG_ADDR, O_TAG_WDATA, I_TAG_RDATA;
    logic       O_NORMAL_END, O_ERROR_END, O_TAG_REQ, O_TAG_WRITE, I_TAG_ACK, I_TAG_FAIL;
    logic       n_prev = 1'b0, e_prev = 1'b0;
    logic [7:0] a, v, b, e;
    logic [9:0] exp_q [$];
    logic [9:0] want;
    int         n_errors = 0, check_count = 0;
    always #12.5 I_CLOCK = ~I_CLOCK;
    tag_byte_read_write_control #(.P_NORM_DLY_CYC(24'h5), .P_OUT_SHORT_CYC(24'h8), .P_OUT_LONG_CYC(24'hC)) dut (
        .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_ADDR_SW(I_ADDR_SW), .I_SELF_TRIG_SW(I_SELF_TRIG_SW),
        .I_OUT_TIME_SW(I_OUT_TIME_SW), .I_COMPARE_READ_SW(I_COMPARE_READ_SW), .I_WRITE_MODE_SW(I_WRITE_MODE_SW),
        .I_HOST_BYTE_IN(I_HOST_BYTE_IN), .I_WRITE_SELECT(I_WRITE_SELECT), .I_ACCESS_START_IN(I_ACCESS_START_IN),
        .I_ACCESS_HOLD_IN(I_ACCESS_HOLD_IN), .O_CARRIER_DATA_OUT(O_CARRIER_DATA_OUT), .O_NORMAL_END(O_NORMAL_END),
        .O_ERROR_END(O_ERROR_END), .I_TAG_PRESENT(I_TAG_PRESENT), .I_TAG_ACK(I_TAG_ACK), .I_TAG_FAIL(I_TAG_FAIL),
        .I_TAG_RDATA(I_TAG_RDATA), .O_TAG_REQ(O_TAG_REQ), .O_TAG_WRITE(O_TAG_WRITE), .O_TAG_ADDR(O_TAG_ADDR),
        .O_TAG_WDATA(O_TAG_WDATA));
    tag_model m (.i_clk(I_CLOCK), .i_req(O_TAG_REQ), .i_write(O_TAG_WRITE), .i_addr(O_TAG_ADDR),
        .i_wdata(O_TAG_WDATA), .i_fault(fault), .o_ack(I_TAG_ACK), .o_fail(I_TAG_FAIL), .o_rdata(I_TAG_RDATA));
    // ==========================================================
    // Checking and closing
    // ==========================================================
    task chk(input string nm, input logic [9:0] seen, input logic [9:0] ex);
        check_count++;
        if (seen !== ex) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk
    task end_sim;
        if (n_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    // An end rising with nothing queued is compared against an impossible value
    always @(posedge I_CLOCK) begin
        n_prev <= O_NORMAL_END;
        e_prev <= O_ERROR_END;
        if (!I_RST && ((O_NORMAL_END && !n_prev) || (O_ERROR_END && !e_prev))) begin
            want = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3FF;
            chk("end", {O_NORMAL_END, O_ERROR_END, O_CARRIER_DATA_OUT}, want);
        end
    end
    initial begin
        repeat (20000) @(posedge I_CLOCK);
        n_errors++;
        end_sim();
    end
    // ==========================================================
    // Stimulus
    // ==========================================================
    task tick;
        @(posedge I_CLOCK);
        #1;
    endtask : tick
    task boot(input logic s, input logic [1:0] ot, input logic c, input logic [1:0] wm);
        @(posedge I_CLOCK);
        I_RST <= 1'b1;
        I_SELF_TRIG_SW <= s;
        I_OUT_TIME_SW <= ot;
        I_COMPARE_READ_SW <= c;
        I_WRITE_MODE_SW <= wm;
        repeat (5) @(posedge I_CLOCK);
        I_RST <= 1'b0;
        repeat (2) tick();
    endtask : boot
    task trig(input logic [7:0] ad, input logic ws, input logic [7:0] hb, input logic [9:0] ex);
        exp_q.push_back(ex);
        @(posedge I_CLOCK);
        I_ADDR_SW <= ad;
        I_WRITE_SELECT <= ws;
        I_HOST_BYTE_IN <= hb;
        @(posedge I_CLOCK);
        I_ACCESS_START_IN <= 1'b1;
        @(posedge I_CLOCK);
        I_ACCESS_START_IN <= 1'b0;
    endtask : trig
    task settle(input logic fall);
        repeat (300) if (!(O_NORMAL_END || O_ERROR_END)) tick();
        if (fall) repeat (300) if (O_NORMAL_END || O_ERROR_END) tick();
    endtask : settle
    initial begin
        void'($urandom(50));
        boot(1'b0, OT_SHORT, 1'b0, WM_BYTE);
        trig(8'h10, 1'b0, 8'h00, 10'h100);
        settle(1'b1);
        I_TAG_PRESENT <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            v = 8'($urandom);
            m.mem[a] = v;
            trig(a, 1'b0, 8'($urandom), {2'b10, v});
            settle(1'b1);
            chk("held data", {2'b00, O_CARRIER_DATA_OUT}, {2'b00, v});
        end
        fault <= 2'h1;
        trig(a, 1'b0, 8'h00, 10'h100);
        settle(1'b1);
        fault <= 2'h0;
        for (int w = 0; w < 3; w++) begin
            boot(1'b0, OT_SHORT, 1'b0, 2'(w));
            a = 8'($urandom);
            v = 8'($urandom);
            b = 8'($urandom);
            m.mem[a] = v;
            e = (w == 0) ? b : (w == 1) ? (v | b) : (v & ~b);
            trig(a, 1'b1, b, {2'b10, e});
            settle(1'b1);
            chk("stored", {2'b00, m.mem[a]}, {2'b00, e});
            fault <= 2'h2;
            trig(a, 1'b1, b, 10'h100);
            settle(1'b1);
            fault <= 2'h0;
        end
        boot(1'b0, OT_LONG, 1'b1, WM_BYTE);
        m.mem[a] = v;
        trig(a, 1'b0, v, 10'h201);
        settle(1'b1);
        trig(a, 1'b0, ~v, 10'h280);
        settle(1'b1);
        boot(1'b0, 2'h2, 1'b0, WM_BYTE);
        trig(a, 1'b0, 8'h00, {2'b10, v});
        settle(1'b0);
        repeat (30) tick();
        chk("end held", {8'h00, O_NORMAL_END, O_ERROR_END}, 10'h002);
        I_TAG_PRESENT <= 1'b0;
        trig(a, 1'b0, 8'h00, 10'h100);
        repeat (3) tick();
        chk("end released", {8'h00, O_NORMAL_END, O_ERROR_END}, 10'h001);
        boot(1'b1, OT_SHORT, 1'b0, WM_BYTE);
        exp_q.push_back({2'b10, v});
        I_TAG_PRESENT <= 1'b1;
        settle(1'b1);
        repeat (30) tick();
        chk("self data", {2'b00, O_CARRIER_DATA_OUT}, {2'b00, v});
        I_ACCESS_HOLD_IN <= 1'b1;
        repeat (2) tick();
        chk("hold data", {2'b00, O_CARRIER_DATA_OUT}, 10'h000);
        m.mem[a] = ~v;
        exp_q.push_back({2'b10, ~v});
        I_ACCESS_HOLD_IN <= 1'b0;
        settle(1'b1);
        chk("queue empty", 10'(exp_q.size()), 10'h000);
        end_sim();
    end
endmodule : tb_tag_byte_read_write_control
